/* File: bench/pfc_regs_props.sv */
// checker of bus answers, power pins, rc gate and flash timer
`timescale 1ns/1ps
`default_nettype none
module pfc_regs_props #(
  parameter logic [31:0] PART_CODE = 32'h0A5A_0001
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire pfc_pkg::pfc_power_t power_off,
  input wire logic rc_clock_enable,
  input wire logic rc_clock_level,
  input wire logic [1:0] flash_wait_cycles,
  input wire logic flash_access_start,
  input wire logic flash_access_busy,
  input wire logic flash_access_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // address phase kept so the data phase can be judged
  logic ap_r;
  logic aw_r;
  logic [31:0] aa_r;
  always_ff @(posedge mclk) begin
    ap_r <= !rst && hsel && htrans[1] && hready;
    aw_r <= hwrite;
    aa_r <= haddr;
  end
  // data phase decodes
  wire logic wr_pw = ap_r && aw_r && aa_r == pfc_pkg::ANALOG_POWER_CONTROL_ADDR;
  wire logic rd_pw = ap_r && !aw_r && aa_r == pfc_pkg::ANALOG_POWER_CONTROL_ADDR;
  wire logic rd_id = ap_r && !aw_r && aa_r == pfc_pkg::PART_IDENTIFICATION_ADDR;
  ////////////////////////////////////////////////////////////////
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  property p_pw_wr; wr_pw |=> {power_off[9:2], power_off[0]} == $past({hwdata[10], hwdata[8:2], hwdata[0]}); endproperty
  a_pw_wr: assert property (p_pw_wr) else $error("power pins late or wrong");
  property p_rst; $fell(rst) |-> power_off == 10'h3D0 && flash_wait_cycles == 2'h2 && rc_clock_enable; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_rc_excl; !(rc_clock_enable && power_off.rc_oscillator_off); endproperty
  a_rc_excl: assert property (p_rc_excl) else $error("rc clock passes while off");
  property p_rc_set; $rose(power_off.rc_oscillator_off) |-> $fell(rc_clock_enable); endproperty
  a_rc_set: assert property (p_rc_set) else $error("rc off without clock stop");
  property p_fl0; flash_access_start && !flash_access_busy && flash_wait_cycles == 2'h0 |=>
    flash_access_busy ##1 flash_access_done && !flash_access_busy; endproperty
  a_fl0: assert property (p_fl0) else $error("flash access length 1 wrong");
  property p_fl1; flash_access_start && !flash_access_busy && flash_wait_cycles == 2'h1 |=>
    flash_access_busy[*2] ##1 flash_access_done && !flash_access_busy; endproperty
  a_fl1: assert property (p_fl1) else $error("flash access length 2 wrong");
  property p_fl2; flash_access_start && !flash_access_busy && flash_wait_cycles[1] |=>
    flash_access_busy[*3] ##1 flash_access_done && !flash_access_busy; endproperty
  a_fl2: assert property (p_fl2) else $error("flash access length 3 wrong");
  property p_rd_pw; rd_pw |-> hrdata[31:11] == 21'h1D && !hrdata[9] && hrdata[10] == power_off[9] &&
    hrdata[8:2] == power_off[8:2] && hrdata[0] == power_off[0]; endproperty
  a_rd_pw: assert property (p_rd_pw) else $error("power readback wrong");
  property p_rd_id; rd_id |-> hrdata == PART_CODE; endproperty
  a_rd_id: assert property (p_rd_id) else $error("part code readback wrong");
  // main scenarios reached
  c_pw: cover property (wr_pw);
  c_rc: cover property ($rose(power_off.rc_oscillator_off));
  c_fl: cover property (flash_access_done);
endmodule
bind pfc_regs pfc_regs_props #(.PART_CODE(PART_CODE)) i_props (.mclk(mclk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .power_off(power_off),
  .rc_clock_enable(rc_clock_enable), .rc_clock_level(rc_clock_level), .flash_wait_cycles(flash_wait_cycles),
  .flash_access_start(flash_access_start), .flash_access_busy(flash_access_busy),
  .flash_access_done(flash_access_done));
`default_nettype wire

/* File: bench/test_pfc_regs.sv */
// self-checking bench for the power, part code and flash wait registers
`timescale 1ns/1ps
`default_nettype none
module test_pfc_regs;
  localparam logic [31:0] CODE = 32'h0C0D_E001; // arbitrary part code
  localparam logic [31:0] PW = pfc_pkg::ANALOG_POWER_CONTROL_ADDR;
  localparam logic [31:0] FL = pfc_pkg::FLASH_WAIT_CONFIG_ADDR;
  logic mclk, rst, hsel, hwrite, rc_clock_level, flash_access_start;
  logic [31:0] haddr, hwdata, rd, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, rc_clock_enable, flash_access_busy, flash_access_done;
  wire logic [31:0] hrdata;
  wire logic [1:0] flash_wait_cycles;
  wire pfc_pkg::pfc_power_t power_off;
  int fails, num_checks, cyc, n, i;
  ////////////////////////////////////////////////////////////////
  pfc_regs #(.PART_CODE(CODE)) i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .power_off(power_off), .rc_clock_enable(rc_clock_enable),
    .rc_clock_level(rc_clock_level), .flash_wait_cycles(flash_wait_cycles),
    .flash_access_start(flash_access_start), .flash_access_busy(flash_access_busy),
    .flash_access_done(flash_access_done));
  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // slow rc clock so clean points come and go; cycle ceiling cuts a hang
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) rc_clock_level <= ~rc_clock_level;
    if (cyc == 4000) begin
      fails++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one single ahb transfer; waits for hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
    {hsize, rc_clock_level, flash_access_start, fails, num_checks, cyc} = {3'h2, 2'b00, 96'h0};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({22'h0, power_off}, 32'h3D0, "power pins after reset");
    bus(1'b0, PW, 32'h0);
    check(rd, 32'hEDD0, "power after reset");
    bus(1'b0, FL, 32'h0);
    check(rd, 32'h2, "flash wait after reset");
    bus(1'b1, pfc_pkg::PART_IDENTIFICATION_ADDR, 32'hFFFF_FFFF);
    bus(1'b0, pfc_pkg::PART_IDENTIFICATION_ADDR, 32'h0);
    check(rd, CODE, "part code");
    bus(1'b1, 32'h4004_8300, 32'hFFFF_FFFF);
    bus(1'b0, 32'h4004_8300, 32'h0);
    check(rd, 32'h0, "unmapped read");
    // walk one power bit at a time, reserved bits kept at their pattern
    for (i = 0; i <= 10; i++) if (i != 9) begin
      d = 32'hE800 | (32'h1 << i);
      bus(1'b1, PW, d);
      bus(1'b0, PW, 32'h0);
      check(rd, d, "power readback");
      check({power_off[9:2], power_off[0]}, {d[10], d[8:2], d[0]}, "power pins");
      if (i == 1) begin
        repeat (12) @(posedge mclk);
        check({rc_clock_enable, power_off.rc_oscillator_off}, 2'b01, "rc stopped");
        bus(1'b0, pfc_pkg::POWER_STATUS_ADDR, 32'h0);
        check(rd, 32'h2, "status rc stopped");
      end
    end
    repeat (12) @(posedge mclk);
    check({rc_clock_enable, power_off.rc_oscillator_off}, 2'b10, "rc restarted");
    bus(1'b0, pfc_pkg::POWER_STATUS_ADDR, 32'h0);
    check(rd, 32'h1, "status rc running");
    // each wait code timed on the port; reserved code 3 must run as slow as code 2
    for (i = 0; i < 4; i++) begin
      bus(1'b1, FL, i);
      bus(1'b0, FL, 32'h0);
      check(rd, i, "flash readback");
      check(flash_wait_cycles, i, "flash wait pins");
      flash_access_start <= 1'b1;
      @(posedge mclk) flash_access_start <= 1'b0;
      n = 0;
      do begin
        @(posedge mclk);
        if (flash_access_busy === 1'b1) n++;
      end while (flash_access_done !== 1'b1 && n < 8);
      check(n, (i == 3) ? 3 : i + 1, "flash access cycles");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: rtl/pfc_flash_wait.sv */
// flash access timer: each access lasts the wait setting plus one cycles, three cycles for reserved code 3
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_wait (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] flash_wait_cycles,
  input wire logic access_start,
  output logic access_busy,
  output logic access_done
);

  logic [1:0] count_r;
  logic [1:0] wait_eff;

  // the reserved code is not trusted, slowest defined timing instead
  assign wait_eff = (flash_wait_cycles == pfc_pkg::FLASH_WAIT_RESERVED_CODE) ?
                    pfc_pkg::FLASH_WAIT_FALLBACK : flash_wait_cycles;

  // a start while busy is ignored; setting is sampled at the start
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_r <= 2'h0;
      access_busy <= 1'b0;
      access_done <= 1'b0;
    end else begin
      access_done <= 1'b0;
      if (!access_busy) begin
        if (access_start) begin
          access_busy <= 1'b1;
          count_r <= wait_eff;
        end
      end else if (count_r == 2'h0) begin
        access_busy <= 1'b0;
        access_done <= 1'b1;
      end else begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pfc_pkg.sv */
// package of constants and types for the power, part code and flash wait register slice
//
// Operation
// - power writes act at once, oscillator excepted
// - oscillator stops at a clean point; from RC_STARTING it stops at once
// - bit 0 powered, 1 off; bits 0-8 ordered
// - reset: bits 0-3,5 zero; 4,6,7,8 one
// - bit 10 suspends usb transceiver, resets one
// - part code read-only 32 bits, writes ignored
// - flash access takes field plus one cycles, three for code 3
package pfc_pkg;

  // byte addresses of the registers, full 32-bit decode
  localparam logic [31:0] FLASH_WAIT_CONFIG_ADDR = 32'h4003_C010;
  localparam logic [31:0] ANALOG_POWER_CONTROL_ADDR = 32'h4004_8238;
  localparam logic [31:0] PART_IDENTIFICATION_ADDR = 32'h4004_83F4;
  localparam logic [31:0] POWER_STATUS_ADDR = 32'h4004_83F8;

  // bit positions in the analog power control word
  localparam int RC_CLOCK_OUTPUT_OFF_BIT = 0;
  localparam int RC_OSCILLATOR_OFF_BIT = 1;
  localparam int NVM_ARRAY_OFF_BIT = 2;
  localparam int BROWNOUT_DETECTOR_OFF_BIT = 3;
  localparam int CONVERTER_OFF_BIT = 4;
  localparam int CRYSTAL_OSCILLATOR_OFF_BIT = 5;
  localparam int WATCHDOG_OSCILLATOR_OFF_BIT = 6;
  localparam int SYSTEM_PLL_OFF_BIT = 7;
  localparam int USB_PLL_OFF_BIT = 8;
  localparam int USB_TRANSCEIVER_OFF_BIT = 10;

  // writable bits of the power word and the fixed pattern of its reserved bits
  localparam logic [15:0] POWER_WRITE_MASK = 16'h05FF;
  localparam logic [15:0] POWER_RESERVED_VALUE = 16'hE800;
  localparam logic [15:0] POWER_RESET_VALUE = 16'hEDD0;

  // flash wait field
  localparam int FLASH_WAIT_LSB = 0;
  localparam int FLASH_WAIT_MSB = 1;
  localparam logic [1:0] FLASH_WAIT_RESET = 2'h2;
  localparam logic [1:0] FLASH_WAIT_RESERVED_CODE = 2'h3;
  localparam logic [1:0] FLASH_WAIT_FALLBACK = 2'h2;

  // status word bit positions
  localparam int STATUS_RC_CLOCK_ENABLED_BIT = 0;
  localparam int STATUS_RC_OSCILLATOR_OFF_BIT = 1;
  localparam int STATUS_FLASH_BUSY_BIT = 2;

  // ahb transfer type msb marks nonseq or seq
  localparam int HTRANS_ACTIVE_BIT = 1;

  // one power-down control for each analog block
  typedef struct packed {
    logic usb_transceiver_off;
    logic usb_pll_off;
    logic system_pll_off;
    logic watchdog_oscillator_off;
    logic crystal_oscillator_off;
    logic converter_off;
    logic brownout_detector_off;
    logic nvm_array_off;
    logic rc_oscillator_off;
    logic rc_clock_output_off;
  } pfc_power_t;

  // captured ahb address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } pfc_addr_phase_t;

  // oscillator gate states
  typedef enum logic [1:0] {
    RC_RUNNING = 2'b00,
    RC_STOPPING = 2'b01,
    RC_STOPPED = 2'b10,
    RC_STARTING = 2'b11
  } pfc_rc_state_t;

endpackage

/* File: rtl/pfc_rc_gate.sv */
// glitch-free stop and restart of the internal rc oscillator clock
`timescale 1ns/1ps
`default_nettype none
module pfc_rc_gate (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rc_off_request,
  input wire logic rc_clock_level,
  output logic rc_clock_enable,
  output logic rc_oscillator_off
);

  logic sync1_r, sync2_r, sync3_r;
  pfc_pkg::pfc_rc_state_t state_r, state_nxt;
  logic clean_point;

  // three-stage synchroniser of the oscillator level
  always_ff @(posedge mclk) begin
    sync1_r <= rc_clock_level;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  // clean point: the last two stages agree the clock is low
  assign clean_point = !sync2_r && !sync3_r;

  // gate the clock in the same cycle power is cut, restore power before the clock
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pfc_pkg::RC_RUNNING: begin
        if (rc_off_request) state_nxt = pfc_pkg::RC_STOPPING;
      end
      pfc_pkg::RC_STOPPING: begin
        if (!rc_off_request) state_nxt = pfc_pkg::RC_RUNNING;
        else if (clean_point) state_nxt = pfc_pkg::RC_STOPPED;
      end
      pfc_pkg::RC_STOPPED: begin
        if (!rc_off_request) state_nxt = pfc_pkg::RC_STARTING;
      end
      pfc_pkg::RC_STARTING: begin
        if (rc_off_request) state_nxt = pfc_pkg::RC_STOPPED;
        else if (clean_point) state_nxt = pfc_pkg::RC_RUNNING;
      end
      default: state_nxt = pfc_pkg::RC_RUNNING;
    endcase
  end

  // outputs registered from the next state
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= pfc_pkg::RC_RUNNING;
      rc_clock_enable <= 1'b1;
      rc_oscillator_off <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rc_clock_enable <= (state_nxt == pfc_pkg::RC_RUNNING) || (state_nxt == pfc_pkg::RC_STOPPING);
      rc_oscillator_off <= (state_nxt == pfc_pkg::RC_STOPPED);
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pfc_regs.sv */
// ahb-lite register slice: analog power control, part code, flash wait setting
`timescale 1ns/1ps
`default_nettype none
module pfc_regs #(
  parameter logic [31:0] PART_CODE = 32'h0A5A_0001 // arbitrary value, set per variant
) (
  input wire logic mclk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog block controls
  output pfc_pkg::pfc_power_t power_off,
  output logic rc_clock_enable,
  input wire logic rc_clock_level,
  // flash timing
  output logic [1:0] flash_wait_cycles,
  input wire logic flash_access_start,
  output logic flash_access_busy,
  output logic flash_access_done
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  pfc_pkg::pfc_addr_phase_t aphase_r, aphase_nxt;
  logic [15:0] power_word_r, power_word_nxt;
  logic [1:0] flash_wait_r, flash_wait_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [31:0] read_addr;
  logic [31:0] power_read, flash_read, status_read;
  logic take_phase;
  logic wr_phase;
  logic hit_flash_wr, hit_power_wr;
  logic rd_flash, rd_power, rd_part, rd_status;
  logic rc_oscillator_off;
  logic rc_clock_enable_int;
  logic flash_busy_int;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  // zero wait states; every answer is okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // a transfer is taken when selected, active and the bus is ready
  assign take_phase = hsel && htrans[pfc_pkg::HTRANS_ACTIVE_BIT] && hready;

  // address phase capture; hsize is not checked, only words are issued
  assign aphase_nxt.valid = take_phase;
  assign aphase_nxt.write = take_phase && hwrite;
  assign aphase_nxt.addr = haddr;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aphase_r <= '0;
    end else begin
      aphase_r <= aphase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode, acting in the data phase

  assign wr_phase = aphase_r.valid && aphase_r.write;
  assign hit_flash_wr = wr_phase && (aphase_r.addr == pfc_pkg::FLASH_WAIT_CONFIG_ADDR);
  assign hit_power_wr = wr_phase && (aphase_r.addr == pfc_pkg::ANALOG_POWER_CONTROL_ADDR);
  // part code and status writes, and unmapped writes, simply fall away

  // power word: defined bits from the write, reserved bits held fixed
  assign power_word_nxt = hit_power_wr ?
      ((hwdata[15:0] & pfc_pkg::POWER_WRITE_MASK) | pfc_pkg::POWER_RESERVED_VALUE) :
      power_word_r;

  // flash wait field; bits above it keep no state and read zero
  assign flash_wait_nxt = hit_flash_wr ?
      hwdata[pfc_pkg::FLASH_WAIT_MSB:pfc_pkg::FLASH_WAIT_LSB] : flash_wait_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      power_word_r <= pfc_pkg::POWER_RESET_VALUE;
      flash_wait_r <= pfc_pkg::FLASH_WAIT_RESET;
    end else begin
      power_word_r <= power_word_nxt;
      flash_wait_r <= flash_wait_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  // read data is latched at the end of the address phase; it is built from
  // the next values so a read right behind a write sees the new word
  assign read_addr = haddr;
  assign rd_flash = (read_addr == pfc_pkg::FLASH_WAIT_CONFIG_ADDR);
  assign rd_power = (read_addr == pfc_pkg::ANALOG_POWER_CONTROL_ADDR);
  assign rd_part = (read_addr == pfc_pkg::PART_IDENTIFICATION_ADDR);
  assign rd_status = (read_addr == pfc_pkg::POWER_STATUS_ADDR);

  // readback words
  assign power_read = {16'h0000, power_word_nxt};
  assign flash_read = {30'h0000_0000, flash_wait_nxt};
  assign status_read = {29'h0000_0000, flash_busy_int, rc_oscillator_off, rc_clock_enable_int};

  // one-hot select, unmapped reads answer zero
  assign hrdata_nxt = (take_phase && !hwrite) ?
      (({32{rd_flash}} & flash_read) |
       ({32{rd_power}} & power_read) |
       ({32{rd_part}} & PART_CODE) |
       ({32{rd_status}} & status_read)) :
      32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else begin
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // analog power controls

  // a set bit powers its block down, a clear bit keeps it powered
  assign power_off.rc_clock_output_off = power_word_r[pfc_pkg::RC_CLOCK_OUTPUT_OFF_BIT];
  assign power_off.nvm_array_off = power_word_r[pfc_pkg::NVM_ARRAY_OFF_BIT];
  assign power_off.brownout_detector_off = power_word_r[pfc_pkg::BROWNOUT_DETECTOR_OFF_BIT];
  assign power_off.converter_off = power_word_r[pfc_pkg::CONVERTER_OFF_BIT];
  assign power_off.crystal_oscillator_off = power_word_r[pfc_pkg::CRYSTAL_OSCILLATOR_OFF_BIT];
  assign power_off.watchdog_oscillator_off = power_word_r[pfc_pkg::WATCHDOG_OSCILLATOR_OFF_BIT];
  assign power_off.system_pll_off = power_word_r[pfc_pkg::SYSTEM_PLL_OFF_BIT];
  assign power_off.usb_pll_off = power_word_r[pfc_pkg::USB_PLL_OFF_BIT];
  assign power_off.usb_transceiver_off = power_word_r[pfc_pkg::USB_TRANSCEIVER_OFF_BIT];

  // the oscillator bit is delayed by the clean-point gate, not driven direct
  assign power_off.rc_oscillator_off = rc_oscillator_off;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator gate

  // the request is the register bit; the gate decides when it is safe
  pfc_rc_gate u_rc_gate (
    .mclk(mclk),
    .rst(rst),
    .rc_off_request(power_word_r[pfc_pkg::RC_OSCILLATOR_OFF_BIT]),
    .rc_clock_level(rc_clock_level),
    .rc_clock_enable(rc_clock_enable_int),
    .rc_oscillator_off(rc_oscillator_off)
  );

  assign rc_clock_enable = rc_clock_enable_int;

  ////////////////////////////////////////////////////////////////////////////
  // flash access timing

  // a wrong setting for the clock rate is the software's risk, not checked
  assign flash_wait_cycles = flash_wait_r;

  pfc_flash_wait u_flash_wait (
    .mclk(mclk),
    .rst(rst),
    .flash_wait_cycles(flash_wait_r),
    .access_start(flash_access_start),
    .access_busy(flash_busy_int),
    .access_done(flash_access_done)
  );

  assign flash_access_busy = flash_busy_int;

endmodule
`default_nettype wire
